// >>> design/eee_global_indirect_regs.sv
// Global low-power-idle registers behind the indirect byte access path
`timescale 1ns/100ps
// Overview of operation
// R1: Control byte table field 001 and target 0 selects the global set.
// R2: Address byte picks register byte; data byte reads or writes it.
// R3: Terminate enable set: input traffic abandons pending idle request.
// R4: Low four diagnostic bits enable next page per port, reset to one.
// R5: Wake-up longer than threshold 0x0201 increments the error count.
// R6: Software leaves threshold alone; it is read-only here.
// R7: Only copper ports; same indirect scheme for global and port sets.
// R8: Reserved read-only fields return defaults; writes to them ignored.
module eee_global_indirect_regs
#(
  parameter int CNT_W = 16
)
(
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata_q,
  input  wire logic                          idle_req_in,
  input  wire logic                          input_traffic,
  output logic                               idle_req_q,
  input  wire logic                          wake_start,
  input  wire logic                          wake_done,
  output logic      [CNT_W-1:0]              wake_err_cnt_q,
  output logic      [eee_global_pkg::NUM_PORTS-1:0] next_page_en_q,
  output logic      [15:0]                   queue_wait_q
);
  import eee_global_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > 32)
  begin : g_bad_cnt_w
    $error("CNT_W out of range");
  end

  // Read word packs the enables below twelve fixed bits
  if (NUM_PORTS != 4)
  begin : g_bad_ports
    $error("NUM_PORTS must be 4");
  end

  // ---------------------------------------------------------------
  // Indirect control and address bytes
  // ---------------------------------------------------------------
  logic [7:0]  ind_ctrl_q;
  logic [7:0]  ind_addr_q;
  logic        term_en_q;
  logic        sel_global;
  logic        data_wr;
  logic [7:0]  ofs_even;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ind_ctrl_q <= 8'h00;
      ind_addr_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_IND_CTRL)
        ind_ctrl_q <= reg_wdata;
      if (reg_addr == ADDR_IND_ADDR)
        ind_addr_q <= reg_wdata; // R2
    end
  end

  // Global set reached only with table 001 and target 0
  assign sel_global =
    (ind_ctrl_q[CTRL_TABLE_MSB:CTRL_TABLE_LSB] == TABLE_EEE) &&
    (ind_ctrl_q[CTRL_TGT_MSB:0] == TARGET_GLOBAL); // R1 R7
  assign data_wr  = reg_wr && (reg_addr == ADDR_IND_DATA) && sel_global;
  assign ofs_even = {ind_addr_q[7:1], 1'b0};

  // ---------------------------------------------------------------
  // Writable fields; even offset is the high byte
  // ---------------------------------------------------------------
  // Only bit 7 of the low byte is writable; the rest is fixed
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      term_en_q <= BUF_TERM_RST;
    else if (data_wr && ind_addr_q == (OFS_BUF_CTRL | 8'h01))
      term_en_q <= reg_wdata[BUF_TERM_BIT]; // R8
  end

  // No auto-increment: each byte is reached by its own offset
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      queue_wait_q <= WAIT_CTRL_RST;
    else if (data_wr && ofs_even == OFS_WAIT_CTRL)
    begin
      if (ind_addr_q[0])
        queue_wait_q[7:0] <= reg_wdata;
      else
        queue_wait_q[15:8] <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      next_page_en_q <= NEXT_PAGE_RST; // R4
    else if (data_wr && ind_addr_q == (OFS_DIAG_CTRL | 8'h01))
      next_page_en_q <= reg_wdata[NUM_PORTS-1:0]; // R4 R8
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (ofs_even)
      OFS_BUF_CTRL:  rd_word = BUF_CTRL_FIXED |
                               {8'h00, term_en_q, 7'h00}; // R8
      OFS_WAIT_CTRL: rd_word = queue_wait_q;
      OFS_DIAG_CTRL: rd_word = DIAG_CTRL_FIXED |
                               {12'h000, next_page_en_q}; // R8
      OFS_MIN_IDLE:  rd_word = MIN_IDLE_VAL;
      OFS_WAKE_THR:  rd_word = WAKE_THR_VAL; // R6
      OFS_GLOB_DIAG: rd_word = GLOB_DIAG_VAL;
      default:       rd_word = 16'h0000;
    endcase
    rd_byte = ind_addr_q[0] ? rd_word[7:0] : rd_word[15:8];
  end

  // Holds the last answer until the next read strobe
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_IND_CTRL)
        reg_rdata_q <= ind_ctrl_q;
      else if (reg_addr == ADDR_IND_ADDR)
        reg_rdata_q <= ind_addr_q;
      else if (reg_addr == ADDR_IND_DATA && sel_global)
        reg_rdata_q <= rd_byte; // R2
      else
        reg_rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Idle request, abandoned by input traffic when enabled
  // ---------------------------------------------------------------
  logic aborted_q;

  // Abandon sticks until the request drops, so a gap in the
  // traffic cannot revive a request that was already given up
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      aborted_q <= 1'b0;
    else if (!idle_req_in)
      aborted_q <= 1'b0;
    else if (term_en_q && input_traffic)
      aborted_q <= 1'b1; // R3
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      idle_req_q <= 1'b0;
    else
      idle_req_q <= idle_req_in && !aborted_q &&
                    !(term_en_q && input_traffic); // R3
  end

  // ---------------------------------------------------------------
  // Wake-up duration check
  // ---------------------------------------------------------------
  logic        waking_q;
  logic        late_q;
  logic [15:0] wake_cnt_q;

  // Counting stops once late: one slow wake-up, one error
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      waking_q   <= 1'b0;
      late_q     <= 1'b0;
      wake_cnt_q <= 16'h0000;
    end
    else if (wake_start)
    begin
      waking_q   <= 1'b1;
      late_q     <= 1'b0;
      wake_cnt_q <= 16'h0000;
    end
    else if (wake_done)
      waking_q <= 1'b0;
    else if (waking_q && !late_q)
    begin
      wake_cnt_q <= wake_cnt_q + 16'h0001;
      if (wake_cnt_q == WAKE_THR_VAL)
        late_q <= 1'b1; // R5
    end
  end

  // Saturates instead of wrapping back to zero
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      wake_err_cnt_q <= '0;
    else if (waking_q && !wake_start && !wake_done && !late_q &&
             wake_cnt_q == WAKE_THR_VAL &&
             wake_err_cnt_q != {CNT_W{1'b1}})
      wake_err_cnt_q <= wake_err_cnt_q + 1'b1; // R5
  end
endmodule

// >>> design/eee_global_pkg.sv
// Constants for the global low-power-idle register set
package eee_global_pkg;
  // ---------------------------------------------------------------
  // Direct byte addresses of the indirect access path
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IND_CTRL  = 8'h6e;
  localparam logic [7:0] ADDR_IND_ADDR  = 8'h6f;
  localparam logic [7:0] ADDR_IND_DATA  = 8'ha0;
  localparam logic [2:0] TABLE_EEE      = 3'h1;
  localparam logic [3:0] TARGET_GLOBAL  = 4'h0;
  localparam int         CTRL_TABLE_MSB = 7;
  localparam int         CTRL_TABLE_LSB = 5;
  localparam int         CTRL_TGT_MSB   = 3;

  // ---------------------------------------------------------------
  // Indirect offsets of the high byte of each 16-bit register
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BUF_CTRL   = 8'h30;
  localparam logic [7:0] OFS_WAIT_CTRL  = 8'h32;
  localparam logic [7:0] OFS_DIAG_CTRL  = 8'h34;
  localparam logic [7:0] OFS_MIN_IDLE   = 8'h36;
  localparam logic [7:0] OFS_WAKE_THR   = 8'h38;
  localparam logic [7:0] OFS_GLOB_DIAG  = 8'h3a;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int          BUF_TERM_BIT     = 7;
  localparam logic [15:0] BUF_CTRL_FIXED   = 16'h4010;
  localparam logic        BUF_TERM_RST     = 1'b0;
  localparam logic [15:0] WAIT_CTRL_RST    = 16'h0010;
  localparam logic [15:0] DIAG_CTRL_FIXED  = 16'h6800;
  localparam logic [3:0]  NEXT_PAGE_RST    = 4'hf;
  localparam logic [15:0] MIN_IDLE_VAL     = 16'h0000;
  localparam logic [15:0] WAKE_THR_VAL     = 16'h0201;
  localparam logic [15:0] GLOB_DIAG_VAL    = 16'h0001;
  localparam int          NUM_PORTS        = 4;
endpackage

// >>> testbench/eee_global_chk_assertions.sv
// Concurrent checks on the global idle register block
`timescale 1ns/100ps
module eee_global_chk #(parameter int CNT_W = 16)
(
  input wire logic             mclk,
  input wire logic             resetn,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata_q,
  input wire logic             idle_req_in,
  input wire logic             input_traffic,
  input wire logic             idle_req_q,
  input wire logic             wake_start,
  input wire logic             wake_done,
  input wire logic [CNT_W-1:0] wake_err_cnt_q,
  input wire logic [3:0]       next_page_en_q,
  input wire logic [15:0]      queue_wait_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_short_wake;
    wake_start ##1 wake_done;
  endsequence
  a_np_reset: assert property (
    $past(resetn) == 1'b0 |-> next_page_en_q == 4'hf)
    else $error("next page enables wrong after reset");
  a_idle_follow: assert property (!idle_req_in |=> !idle_req_q)
    else $error("idle request without input request");
  a_idle_cause: assert property (
    $rose(idle_req_q) |-> $past(idle_req_in))
    else $error("idle request rose without cause");
  a_idle_keep: assert property (
    idle_req_in && !input_traffic && idle_req_q |=> idle_req_q)
    else $error("idle request dropped without traffic");
  a_err_step: assert property (
    $past(resetn) && $changed(wake_err_cnt_q) |->
    wake_err_cnt_q == $past(wake_err_cnt_q) + 1'b1)
    else $error("error count moved by other than one");
  a_short_wake: assert property (
    s_short_wake |=> $stable(wake_err_cnt_q) [*3])
    else $error("short wake counted as error");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without read");
  a_cfg_hold: assert property (
    !reg_wr |=> $stable(queue_wait_q) && $stable(next_page_en_q))
    else $error("config changed without write");
endmodule
bind eee_global_indirect_regs eee_global_chk #(.CNT_W(CNT_W))
  i_eee_global_chk (
    .mclk           (mclk),
    .resetn         (resetn),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata_q    (reg_rdata_q),
    .idle_req_in    (idle_req_in),
    .input_traffic  (input_traffic),
    .idle_req_q     (idle_req_q),
    .wake_start     (wake_start),
    .wake_done      (wake_done),
    .wake_err_cnt_q (wake_err_cnt_q),
    .next_page_en_q (next_page_en_q),
    .queue_wait_q   (queue_wait_q)
  );

// >>> testbench/eee_global_indirect_regs_tb.sv
// Self-checking bench for the global idle register block
`timescale 1ns/100ps
module eee_global_indirect_regs_tb;
  import eee_global_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        idle_req_in = 1'b0, input_traffic = 1'b0, idle_req_q;
  logic        wake_start = 1'b0, wake_done = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
  logic [15:0] wake_err_cnt_q, queue_wait_q;
  logic [3:0]  next_page_en_q;
  int          n_errors = 0, check_count = 0;
  eee_global_indirect_regs i_eee_global_indirect_regs (
    .mclk           (mclk),
    .resetn         (resetn),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata_q    (reg_rdata_q),
    .idle_req_in    (idle_req_in),
    .input_traffic  (input_traffic),
    .idle_req_q     (idle_req_q),
    .wake_start     (wake_start),
    .wake_done      (wake_done),
    .wake_err_cnt_q (wake_err_cnt_q),
    .next_page_en_q (next_page_en_q),
    .queue_wait_q   (queue_wait_q)
  );
  always #5 mclk = ~mclk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Lets outputs launched at the last edge settle before sampling
  task automatic settle;
    @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    step(1);
    reg_wr <= 1'b0;
    settle;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    step(1);
    reg_addr <= a;
    reg_rd <= 1'b1;
    step(1);
    reg_rd <= 1'b0;
    settle;
    chk({8'h00, reg_rdata_q}, {8'h00, e});
  endtask
  task automatic ir(input logic [7:0] o, input logic [7:0] e);
    wr(ADDR_IND_ADDR, o);
    rd(ADDR_IND_DATA, e);
  endtask
  task automatic iw(input logic [7:0] o, input logic [7:0] d);
    wr(ADDR_IND_ADDR, o);
    wr(ADDR_IND_DATA, d);
  endtask
  task automatic t_reset;
    logic [7:0] ofs [11] = '{8'h30, 8'h31, 8'h34, 8'h35, 8'h36, 8'h37,
                             8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c};
    logic [7:0] exp [11] = '{8'h40, 8'h10, 8'h68, 8'h0f, 8'h00, 8'h00,
                             8'h02, 8'h01, 8'h00, 8'h01, 8'h00};
    settle;
    chk(next_page_en_q, 16'h000f);
    chk(queue_wait_q, 16'h0010);
    wr(ADDR_IND_CTRL, 8'h20);
    foreach (ofs[i]) ir(ofs[i], exp[i]);
    $display("reset values done");
  endtask
  task automatic t_write;
    iw(8'h34, 8'hff);
    iw(8'h35, 8'hf5);
    chk(next_page_en_q, 16'h0005);
    ir(8'h34, 8'h68);
    ir(8'h35, 8'h05);
    iw(8'h38, 8'hff);
    ir(8'h38, 8'h02);
    iw(8'h32, 8'h12);
    iw(8'h33, 8'h34);
    chk(queue_wait_q, 16'h1234);
    ir(8'h32, 8'h12);
    ir(8'h33, 8'h34);
    $display("writes done");
  endtask
  task automatic t_table;
    wr(ADDR_IND_CTRL, 8'h40);
    iw(8'h35, 8'h0a);
    chk(next_page_en_q, 16'h0005);
    ir(8'h35, 8'h00);
    wr(ADDR_IND_CTRL, 8'h21);
    iw(8'h35, 8'h0a);
    chk(next_page_en_q, 16'h0005);
    rd(ADDR_IND_CTRL, 8'h21);
    rd(ADDR_IND_ADDR, 8'h35);
    rd(8'h00, 8'h00);
    wr(ADDR_IND_CTRL, 8'h20);
    $display("table select done");
  endtask
  task automatic idle(input logic r, input logic t, input logic e);
    step(1);
    idle_req_in <= r;
    input_traffic <= t;
    step(2);
    settle;
    chk(idle_req_q, e);
  endtask
  task automatic t_idle;
    idle(1'b1, 1'b0, 1'b1);
    idle(1'b1, 1'b1, 1'b1);
    iw(8'h31, 8'h80);
    ir(8'h31, 8'h90);
    idle(1'b1, 1'b1, 1'b0);
    idle(1'b1, 1'b0, 1'b0);
    idle(1'b0, 1'b0, 1'b0);
    idle(1'b1, 1'b0, 1'b1);
    $display("idle request done");
  endtask
  task automatic wake(input int n, input logic [15:0] e);
    step(1);
    wake_start <= 1'b1;
    step(1);
    wake_start <= 1'b0;
    step(n);
    wake_done <= 1'b1;
    step(1);
    wake_done <= 1'b0;
    step(3);
    settle;
    chk(wake_err_cnt_q, e);
  endtask
  task automatic t_wake;
    wake(0, 16'h0000);
    wake(16'h01f8, 16'h0000);
    wake(16'h0210, 16'h0001);
    wake(16'h0220, 16'h0002);
    $display("wake check done");
  endtask
  task automatic t_rerun;
    step(1);
    resetn <= 1'b0;
    step(2);
    settle;
    chk(idle_req_q, 16'h0000);
    chk(wake_err_cnt_q, 16'h0000);
    step(1);
    resetn <= 1'b1;
    settle;
    chk(next_page_en_q, 16'h000f);
    chk(queue_wait_q, 16'h0010);
    rd(ADDR_IND_CTRL, 8'h00);
    $display("mid-run reset done");
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    results;
  end
  initial
  begin
    step(5);
    resetn <= 1'b1;
    t_reset;
    t_write;
    t_table;
    t_idle;
    t_wake;
    t_rerun;
    results;
  end
endmodule
